// File: design/pcs_sequencer.sv
// Positioning chain sequencer: runs stored entries one-shot, chained, or chained with dwell.
// Assumes a host on discrete lines (select, start, ready, moving) and software on Avalon-MM.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_sequencer #(
    parameter int unsigned DWELL_TICK_CYC = `PCS_DWELL_UNIT_NS / `PCS_CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic [3:0]  entry_select_lines,
    input  wire logic        start,
    output logic             ready,
    output logic             moving,
    output logic             alarm,
    output logic      [31:0] cmd_pos,
    output logic      [15:0] torque_limit,
    output logic      [15:0] accel_time,
    output logic      [15:0] decel_time
);
    localparam logic [17:0] TICK_LAST = 18'(DWELL_TICK_CYC - 1);

    pcs_pkg::pcs_seq_t   s_q;
    pcs_pkg::pcs_seq_t   s_d;
    pcs_pkg::pcs_entry_t ent;
    pcs_pkg::pcs_entry_t ent_b;

    logic [127:0] rd_a;
    logic [127:0] rd_b;
    logic         acc;
    logic         mem_we;
    logic         axis_done;
    logic [31:0]  axis_pos;
    logic         start_acc;
    logic [31:0]  nxt_pos;
    logic         nxt_dir;
    logic         dir_err;
    logic         len_err;
    logic         links;

    // Bus request taken only while waitrequest is high
    assign acc    = (avs_read || avs_write) && s_q.wait_rq;
    assign mem_we = acc && avs_write && (avs_address[9:8] == `PCS_ENTRY_PAGE);

    assign ent   = pcs_pkg::pcs_entry_t'(rd_a);
    assign ent_b = pcs_pkg::pcs_entry_t'(rd_b);

    assign start_acc = (s_q.st == pcs_pkg::PCS_IDLE) && start && !s_q.start_prev
                       && s_q.ready && !s_q.alarm;

    // Whole chain is vetted before any motion, so a refused chain never moves
    // Chain scan: predicted position and direction of each entry
    assign nxt_pos = ent.absolute_target ? ent.target : s_q.pos + ent.target;
    assign nxt_dir = $signed(nxt_pos) < $signed(s_q.pos);
    assign dir_err = (s_q.cnt != 3'h0) && s_q.prev_link && (nxt_dir != s_q.prev_dir);
    assign len_err = (s_q.cnt == `PCS_MAX_CHAIN);
    assign links   = ((ent.func == `PCS_FN_CHAIN) || (ent.func == `PCS_FN_PAUSE))
                     && (s_q.idx != `PCS_LAST_ENTRY);

    // Port b follows the select lines live, so the torque limit tracks them mid chain
    pcs_entry_mem u_mem (
        .clk     (clk),
        .reset_n (reset_n),
        .we      (mem_we),
        .waddr   (avs_address[7:2]),
        .wdata   (avs_writedata),
        .wbe     (avs_byteenable),
        .addr_a  (s_q.idx),
        .addr_b  (entry_select_lines),
        .rdata_a (rd_a),
        .rdata_b (rd_b)
    );

    pcs_axis u_axis (
        .clk      (clk),
        .reset_n  (reset_n),
        .load     (s_q.ld),
        .load_tgt (s_q.ld_tgt),
        .load_spd (s_q.ld_spd),
        .cmd_pos  (axis_pos),
        .busy     (),
        .done     (axis_done)
    );

    always_comb begin
        logic [`PCS_IRQ_W-1:0] ev;
        logic [`PCS_IRQ_W-1:0] clr;
        ev           = '0;
        clr          = '0;
        s_d          = s_q;
        s_d.ld       = 1'b0;
        s_d.start_prev = start;
        s_d.wait_rq  = 1'b1;

        // Register slave: answer one clock after the request is seen
        if (acc) begin
            s_d.wait_rq = 1'b0;
            s_d.rdata   = `PCS_RDATA_RST;
            if (avs_read) begin
                case (avs_address)
                    `PCS_STATUS_OFS: begin
                        s_d.rdata[`PCS_ST_READY]            = s_q.ready;
                        s_d.rdata[`PCS_ST_MOVING]           = s_q.moving;
                        s_d.rdata[`PCS_ST_ALARM]            = s_q.alarm;
                        s_d.rdata[`PCS_ST_IDX_LSB +: 4]     = s_q.idx;
                    end
                    `PCS_IRQ_STAT_OFS: begin
                        s_d.rdata[`PCS_IRQ_W-1:0] = s_q.irq_stat;
                        clr                       = s_q.irq_stat;
                    end
                    `PCS_IRQ_MASK_OFS: begin
                        s_d.rdata[`PCS_IRQ_W-1:0] = s_q.irq_mask;
                    end
                    `PCS_CMD_POS_OFS: begin
                        s_d.rdata = axis_pos;
                    end
                    default: begin
                        s_d.rdata = `PCS_RDATA_RST;
                    end
                endcase
            end else begin
                case (avs_address)
                    `PCS_CTRL_OFS: begin
                        if (avs_byteenable[0] && avs_writedata[`PCS_CTRL_ALM_CLR]) begin
                            s_d.alarm = 1'b0;
                        end
                    end
                    `PCS_IRQ_MASK_OFS: begin
                        if (avs_byteenable[0]) begin
                            s_d.irq_mask = avs_writedata[`PCS_IRQ_W-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        case (s_q.st)
            pcs_pkg::PCS_IDLE: begin
                s_d.ready = !s_d.alarm;
                if (start_acc) begin
                    s_d.idx       = entry_select_lines;
                    s_d.start_idx = entry_select_lines;
                    s_d.cnt       = 3'h0;
                    s_d.pos       = axis_pos;
                    s_d.prev_link = 1'b0;
                    s_d.ready     = 1'b0;
                    s_d.st        = pcs_pkg::PCS_SCAN_RD;
                end
            end
            pcs_pkg::PCS_SCAN_RD: begin
                s_d.st = pcs_pkg::PCS_SCAN_CHK;
            end
            pcs_pkg::PCS_SCAN_CHK: begin
                s_d.cnt       = s_q.cnt + 3'h1;
                s_d.pos       = nxt_pos;
                s_d.prev_dir  = nxt_dir;
                s_d.prev_link = (ent.func == `PCS_FN_CHAIN);
                if (dir_err || len_err) begin
                    // Chain refused before any motion; ready stays low until cleared
                    s_d.alarm     = 1'b1;
                    ev[`PCS_IRQ_ALARM] = 1'b1;
                    s_d.idx       = s_q.start_idx;
                    s_d.st        = pcs_pkg::PCS_IDLE;
                end else if (links) begin
                    s_d.idx = s_q.idx + 4'h1;
                    s_d.st  = pcs_pkg::PCS_SCAN_RD;
                end else begin
                    s_d.idx   = s_q.start_idx;
                    s_d.first = 1'b1;
                    s_d.st    = pcs_pkg::PCS_RUN_RD;
                end
            end
            pcs_pkg::PCS_RUN_RD: begin
                s_d.st = pcs_pkg::PCS_RUN_LOAD;
            end
            pcs_pkg::PCS_RUN_LOAD: begin
                // Incremental targets build on where the last move really ended
                s_d.ld     = 1'b1;
                s_d.ld_tgt = ent.absolute_target ? ent.target
                                                 : axis_pos + ent.target;
                s_d.ld_spd = ent.speed;
                s_d.moving = 1'b1;
                s_d.func   = links ? ent.func : `PCS_FN_ONESHOT;
                s_d.dwell  = ent.dwell;
                if (s_q.first) begin
                    s_d.accel = ent.accel;
                    s_d.decel = ent.decel;
                    s_d.first = 1'b0;
                end
                s_d.st = pcs_pkg::PCS_MOVING;
            end
            pcs_pkg::PCS_MOVING: begin
                if (axis_done) begin
                    case (s_q.func)
                        `PCS_FN_CHAIN: begin
                            // Moving stays high: no rest between plain entries
                            s_d.idx = s_q.idx + 4'h1;
                            s_d.st  = pcs_pkg::PCS_RUN_RD;
                        end
                        `PCS_FN_PAUSE: begin
                            s_d.moving = 1'b0;
                            s_d.tick   = 18'h00000;
                            s_d.st     = pcs_pkg::PCS_DWELL;
                        end
                        default: begin
                            s_d.moving = 1'b0;
                            s_d.ready  = 1'b1;
                            ev[`PCS_IRQ_DONE] = 1'b1;
                            s_d.st     = pcs_pkg::PCS_IDLE;
                        end
                    endcase
                end
            end
            pcs_pkg::PCS_DWELL: begin
                // Ready is untouched here, so it stays low through the pause
                // A zero dwell still spends one cycle here before the next read
                if (s_q.dwell == 16'h0000) begin
                    s_d.idx = s_q.idx + 4'h1;
                    s_d.st  = pcs_pkg::PCS_RUN_RD;
                end else if (s_q.tick == TICK_LAST) begin
                    s_d.tick  = 18'h00000;
                    s_d.dwell = s_q.dwell - 16'h0001;
                end else begin
                    s_d.tick = s_q.tick + 18'h00001;
                end
            end
            default: begin
                s_d.st = pcs_pkg::PCS_IDLE;
            end
        endcase

        // A new event wins over the read that clears it
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q          <= '0;
            s_q.st       <= pcs_pkg::PCS_IDLE;
            s_q.wait_rq  <= 1'b1;
            s_q.irq_mask <= `PCS_IRQ_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.wait_rq;
    assign irq             = s_q.irq;
    assign ready           = s_q.ready;
    assign moving          = s_q.moving;
    assign alarm           = s_q.alarm;
    assign cmd_pos         = axis_pos;
    assign torque_limit    = rd_b[111:96];
    assign accel_time      = s_q.accel;
    assign decel_time      = s_q.decel;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_dwell_over;
        (s_q.st == pcs_pkg::PCS_DWELL) && (s_q.dwell == 16'h0000);
    endsequence

    sequence s_next_load;
        (s_q.st == pcs_pkg::PCS_RUN_RD) ##1 (s_q.st == pcs_pkg::PCS_RUN_LOAD) ##1 (s_q.ld && moving);
    endsequence

    a_start_drops_ready: assert property (start_acc |=> !ready [*2])
        else $error("ready did not drop after start");
    a_busy_not_ready: assert property ((s_q.st != pcs_pkg::PCS_IDLE) |-> !ready)
        else $error("ready high while a chain runs");
    a_dwell_resumes: assert property (s_dwell_over |=> s_next_load)
        else $error("dwell end did not start the next move");
    a_dwell_idle_move: assert property ((s_q.st == pcs_pkg::PCS_DWELL) |-> !moving)
        else $error("moving high during dwell");
    a_chain_no_rest: assert property ((s_q.st == pcs_pkg::PCS_MOVING && axis_done
        && s_q.func == `PCS_FN_CHAIN) |=> moving [*3])
        else $error("moving dropped between plain chained entries");
    a_oneshot_stop: assert property ((s_q.st == pcs_pkg::PCS_MOVING && axis_done
        && s_q.func == `PCS_FN_ONESHOT) |=> (ready && !moving && s_q.st == pcs_pkg::PCS_IDLE))
        else $error("one-shot end did not stop and return ready");
    a_last_no_wrap: assert property ((s_q.st == pcs_pkg::PCS_RUN_LOAD
        && s_q.idx == `PCS_LAST_ENTRY) |=> (s_q.func == `PCS_FN_ONESHOT))
        else $error("entry 15 chained onward");
    a_long_chain: assert property ((s_q.st == pcs_pkg::PCS_SCAN_CHK
        && s_q.cnt == `PCS_MAX_CHAIN) |=> (alarm && s_q.st == pcs_pkg::PCS_IDLE))
        else $error("fifth chained entry did not raise the alarm");
    a_mixed_dir: assert property ((s_q.st == pcs_pkg::PCS_SCAN_CHK && dir_err)
        |=> alarm ##1 !moving)
        else $error("mixed plain chain did not raise the alarm");
    a_ramp_hold: assert property ((s_q.st == pcs_pkg::PCS_RUN_LOAD && !s_q.first)
        |=> $stable(accel_time) && $stable(decel_time))
        else $error("ramp times changed inside a chain");
    a_abs_target: assert property ((s_q.st == pcs_pkg::PCS_RUN_LOAD
        && ent.absolute_target) |=> (s_q.ld_tgt == $past(ent.target)))
        else $error("absolute target not taken directly");

    // One accept per request: a held request must not be taken twice
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles in a row");
    a_start_ignored: assert property ((s_q.st == pcs_pkg::PCS_IDLE)
        && !ready && start |=> (s_q.st == pcs_pkg::PCS_IDLE))
        else $error("start taken while ready was low");
    a_select_entry: assert property (start_acc
        |=> (s_q.idx == $past(entry_select_lines)))
        else $error("chain did not start at the selected entry");
    a_dwell_still: assert property ((s_q.st == pcs_pkg::PCS_DWELL)
        |=> $stable(cmd_pos))
        else $error("command position moved during dwell");
    a_alarm_still: assert property ($rose(alarm) |-> !moving && !s_q.ld)
        else $error("alarm raised while a move was under way");
    a_done_event: assert property ((s_q.st == pcs_pkg::PCS_MOVING && axis_done
        && s_q.func == `PCS_FN_ONESHOT) |=> s_q.irq_stat[`PCS_IRQ_DONE])
        else $error("chain end did not set the done event");
    a_pause_drops: assert property ((s_q.st == pcs_pkg::PCS_MOVING && axis_done
        && s_q.func == `PCS_FN_PAUSE) |=> (!moving && s_q.st == pcs_pkg::PCS_DWELL))
        else $error("moving did not drop at the end of a dwell-chained move");
endmodule : pcs_sequencer

// File: design/pcs_map.svh
// Address map, field values, reset values and timing counts of the chain sequencer.
// Assumes a 250 MHz clock and a byte-addressed Avalon-MM register window.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// Byte offsets of the register window
`define PCS_CTRL_OFS        10'h000
`define PCS_STATUS_OFS      10'h004
`define PCS_IRQ_STAT_OFS    10'h008
`define PCS_IRQ_MASK_OFS    10'h00C
`define PCS_CMD_POS_OFS     10'h010
`define PCS_ENTRY_PAGE      2'h1

// Control and status bits
`define PCS_CTRL_ALM_CLR    0
`define PCS_ST_READY        0
`define PCS_ST_MOVING       1
`define PCS_ST_ALARM        2
`define PCS_ST_IDX_LSB      4
`define PCS_IRQ_DONE        0
`define PCS_IRQ_ALARM       1
`define PCS_IRQ_W           2

// Entry function codes
`define PCS_FN_ONESHOT      2'h0
`define PCS_FN_CHAIN        2'h1
`define PCS_FN_PAUSE        2'h2

`define PCS_LAST_ENTRY      4'hF
`define PCS_MAX_CHAIN       3'h4

// Reset values
`define PCS_IRQ_MASK_RST    2'h0
`define PCS_RDATA_RST       32'h0000_0000

// Timing: dwell is counted in milliseconds
`define PCS_CLK_PERIOD_NS   4
`define PCS_DWELL_UNIT_NS   1000000

`endif

// File: design/pcs_pkg.sv
// Types shared by the chain sequencer, its entry store and its axis stepper.
// Constants live in pcs_map.svh.
package pcs_pkg;

    typedef enum logic [2:0] {
        PCS_IDLE,
        PCS_SCAN_RD,
        PCS_SCAN_CHK,
        PCS_RUN_RD,
        PCS_RUN_LOAD,
        PCS_MOVING,
        PCS_DWELL
    } pcs_state_t;

    // One stored entry, four 32-bit words, word 0 in the low bits
    typedef struct packed {
        logic [15:0] dwell;
        logic [15:0] torque;
        logic [15:0] decel;
        logic [15:0] accel;
        logic [12:0] rsv;
        logic [1:0]  func;
        logic        absolute_target;
        logic [15:0] speed;
        logic [31:0] target;
    } pcs_entry_t;

    typedef struct packed {
        pcs_state_t  st;
        logic        start_prev;
        logic        ready;
        logic        moving;
        logic        alarm;
        logic        first;
        logic [3:0]  idx;
        logic [3:0]  start_idx;
        logic [2:0]  cnt;
        logic [31:0] pos;
        logic        prev_dir;
        logic        prev_link;
        logic [1:0]  func;
        logic [15:0] dwell;
        logic [17:0] tick;
        logic        ld;
        logic [31:0] ld_tgt;
        logic [15:0] ld_spd;
        logic [15:0] accel;
        logic [15:0] decel;
        logic        wait_rq;
        logic [31:0] rdata;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
    } pcs_seq_t;

    typedef struct packed {
        logic [15:0][127:0] mem;
        logic [127:0]       rd_a;
        logic [127:0]       rd_b;
    } pcs_mem_t;

    typedef struct packed {
        logic [31:0] pos;
        logic [31:0] tgt;
        logic [15:0] spd;
        logic        busy;
        logic        done;
    } pcs_axis_t;

endpackage : pcs_pkg

// File: design/pcs_entry_mem.sv
// Sixteen-entry store for positioning entries, one word write port, two read ports.
// Read data appear one clock after the address; byte enables mask the write.
`timescale 1ns/1ps
module pcs_entry_mem (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         we,
    input  wire logic [5:0]   waddr,
    input  wire logic [31:0]  wdata,
    input  wire logic [3:0]   wbe,
    input  wire logic [3:0]   addr_a,
    input  wire logic [3:0]   addr_b,
    output logic      [127:0] rdata_a,
    output logic      [127:0] rdata_b
);
    pcs_pkg::pcs_mem_t s_q;
    pcs_pkg::pcs_mem_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.rd_a = s_q.mem[addr_a];
        s_d.rd_b = s_q.mem[addr_b];
        for (int b = 0; b < 4; b++) begin
            if (we && wbe[b]) begin
                s_d.mem[waddr[5:2]][{waddr[1:0], 5'h00} + 7'(b * 8) +: 8] = wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_a = s_q.rd_a;
    assign rdata_b = s_q.rd_b;
endmodule : pcs_entry_mem

// File: design/pcs_axis.sv
// Command position stepper: moves the command position toward a loaded target
// by the loaded speed each clock and pulses done on arrival.
`timescale 1ns/1ps
module pcs_axis (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        load,
    input  wire logic [31:0] load_tgt,
    input  wire logic [15:0] load_spd,
    output logic      [31:0] cmd_pos,
    output logic             busy,
    output logic             done
);
    pcs_pkg::pcs_axis_t s_q;
    pcs_pkg::pcs_axis_t s_d;
    logic signed [32:0] diff;

    assign diff = $signed({s_q.tgt[31], s_q.tgt}) - $signed({s_q.pos[31], s_q.pos});

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.tgt  = load_tgt;
            // A zero speed would never arrive
            s_d.spd  = (load_spd == 16'h0000) ? 16'h0001 : load_spd;
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            if ((diff <= $signed({17'h00000, s_q.spd}))
                && (diff >= -$signed({17'h00000, s_q.spd}))) begin
                s_d.pos  = s_q.tgt;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else if (diff > 0) begin
                s_d.pos = s_q.pos + {16'h0000, s_q.spd};
            end else begin
                s_d.pos = s_q.pos - {16'h0000, s_q.spd};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_pos = s_q.pos;
    assign busy    = s_q.busy;
    assign done    = s_q.done;
endmodule : pcs_axis

// File: dv/pcs_host_model.sv
// Host controller model on the discrete lines: entry select and start.
// Assumes ready from the sequencer; every line changes just after a rising clock edge.
`timescale 1ns/1ps
module pcs_host_model (
    input  wire logic       clk,
    input  wire logic       ready,
    output logic      [3:0] entry_select_lines,
    output logic            start
);
    initial begin
        entry_select_lines = 4'h0;
        start = 1'b0;
    end

    task automatic pick(input logic [3:0] n);
        @(posedge clk);
        entry_select_lines <= n;
    endtask : pick

    // Start waits for ready and is held until ready is seen low, never a fixed count
    task automatic go(input logic [3:0] n);
        int k;
        pick(n);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ready !== 1'b1 && k < 5000);
        start <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (ready !== 1'b0 && k < 10000);
        start <= 1'b0;
    endtask : go
endmodule : pcs_host_model

// File: dv/positioning_chain_sequencer_tb_top.sv
// Self-checking bench of the chain sequencer: Avalon-MM tasks plus a host model.
// Assumes the entry store resets to zero and a shortened dwell tick of 4 clocks.
`timescale 1ns/1ps
`include "pcs_map.svh"
module positioning_chain_sequencer_tb_top;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, start, ready, moving, alarm;
    logic [3:0]  sel;
    logic [31:0] cmd_pos, q;
    logic [15:0] torque_limit, accel_time, decel_time;
    logic        mv_d, rd_d;
    int          bad_count = 0, tests_run = 0, mfall = 0, rrise = 0, m0, r0;

    always #2 clk = ~clk;

    pcs_sequencer #(.DWELL_TICK_CYC(4)) u_dut (.clk(clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .entry_select_lines(sel),
        .start(start), .ready(ready), .moving(moving), .alarm(alarm), .cmd_pos(cmd_pos),
        .torque_limit(torque_limit), .accel_time(accel_time), .decel_time(decel_time));
    pcs_host_model u_host (.clk(clk), .ready(ready), .entry_select_lines(sel), .start(start));

    // Edge counters let a test tell a stop between moves from a straight run
    always @(posedge clk) begin
        mv_d <= moving;
        rd_d <= ready;
        if (mv_d === 1'b1 && moving === 1'b0) mfall <= mfall + 1;
        if (rd_d === 1'b0 && ready === 1'b1) rrise <= rrise + 1;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] rq);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 100);
        if (k >= 100) chk("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic put(input logic [3:0] n, input logic [31:0] tg, input logic [1:0] fn,
                       input logic ab, input logic [31:0] w2, input logic [31:0] w3);
        logic [9:0] b;
        b = 10'h100 + {2'h0, n, 4'h0};
        bus(1'b1, b, tg, q);
        bus(1'b1, b + 10'h004, {13'h0, fn, ab, 16'h0032}, q);
        bus(1'b1, b + 10'h008, w2, q);
        bus(1'b1, b + 10'h00C, w3, q);
    endtask : put

    task automatic wait_on(input logic use_alarm);
        int k;
        k = 0;
        while ((use_alarm ? alarm : ready) !== 1'b1 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        chk(use_alarm ? "alarm" : "ready", {31'h0, use_alarm ? alarm : ready}, 32'h1);
    endtask : wait_on

    task automatic run(input logic [3:0] n, input logic use_alarm);
        m0 = mfall;
        r0 = rrise;
        u_host.go(n);
        wait_on(use_alarm);
        @(posedge clk);
    endtask : run

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        wait_on(1'b0);
        bus(1'b0, `PCS_IRQ_MASK_OFS, 32'h0, q);
        chk("mask reset", q, 32'h0);
        bus(1'b0, 10'h3F0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
        put(4'h1, 32'h1388, `PCS_FN_ONESHOT, 1'b0, 32'h0, 32'h0);
        run(4'h1, 1'b0);
        chk("one-shot pos", cmd_pos, 32'h1388);
        bus(1'b0, `PCS_CMD_POS_OFS, 32'h0, q);
        chk("position register", q, 32'h1388);
        bus(1'b0, `PCS_IRQ_STAT_OFS, 32'h0, q);
        chk("done event", q, 32'h1);
        bus(1'b0, `PCS_IRQ_STAT_OFS, 32'h0, q);
        chk("read clears", q, 32'h0);
        $display("test one-shot done");
        put(4'h2, 32'h64, `PCS_FN_CHAIN, 1'b0, 32'h0008_0007, 32'h0);
        put(4'h3, 32'hC8, `PCS_FN_ONESHOT, 1'b0, 32'h0004_0003, 32'h0);
        run(4'h2, 1'b0);
        chk("chain pos", cmd_pos, 32'h14B4);
        chk("chain stops", mfall - m0, 32'h1);
        chk("ramp", {decel_time, accel_time}, 32'h0008_0007);
        $display("test chain done");
        put(4'h4, 32'hA, `PCS_FN_PAUSE, 1'b0, 32'h0, 32'h0002_0000);
        put(4'h5, 32'hFFFF_FFEC, `PCS_FN_ONESHOT, 1'b1, 32'h0, 32'h0);
        run(4'h4, 1'b0);
        chk("dwell pos", cmd_pos, 32'hFFFF_FFEC);
        chk("moving drops", mfall - m0, 32'h2);
        chk("ready once", rrise - r0, 32'h1);
        $display("test dwell done");
        put(4'hF, 32'h1, `PCS_FN_CHAIN, 1'b0, 32'h0, 32'h0);
        run(4'hF, 1'b0);
        chk("last alarm", {31'h0, alarm}, 32'h0);
        chk("last entry", cmd_pos, 32'hFFFF_FFED);
        bus(1'b0, `PCS_STATUS_OFS, 32'h0, q);
        chk("last status", q, 32'h0000_00F1);
        $display("test last entry done");
        bus(1'b0, `PCS_IRQ_STAT_OFS, 32'h0, q);
        chk("stale done", q, 32'h1);
        bus(1'b1, `PCS_IRQ_MASK_OFS, 32'h3, q);
        put(4'h6, 32'h5, `PCS_FN_CHAIN, 1'b0, 32'h0, 32'h0);
        put(4'h7, 32'hFFFF_FFFB, `PCS_FN_ONESHOT, 1'b0, 32'h0, 32'h0);
        run(4'h6, 1'b1);
        repeat (3) @(posedge clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        chk("no motion", cmd_pos, 32'hFFFF_FFED);
        bus(1'b0, `PCS_IRQ_STAT_OFS, 32'h0, q);
        chk("alarm event", q, 32'h2);
        repeat (3) @(posedge clk);
        chk("irq clears", {31'h0, irq}, 32'h0);
        bus(1'b1, `PCS_CTRL_OFS, 32'h1, q);
        wait_on(1'b0);
        $display("test direction done");
        for (int i = 8; i < 12; i++) put(i[3:0], 32'h1, `PCS_FN_CHAIN, 1'b0, 32'h0, 32'h0);
        put(4'hC, 32'h1, `PCS_FN_ONESHOT, 1'b0, 32'h0, 32'h0);
        run(4'h8, 1'b1);
        chk("five entries", cmd_pos, 32'hFFFF_FFED);
        bus(1'b1, `PCS_CTRL_OFS, 32'h1, q);
        run(4'h9, 1'b0);
        chk("four alarm", {31'h0, alarm}, 32'h0);
        chk("four entries", cmd_pos, 32'hFFFF_FFF1);
        $display("test chain length done");
        put(4'hD, 32'h0, `PCS_FN_ONESHOT, 1'b0, 32'h0, 32'h0000_0055);
        u_host.pick(4'hD);
        repeat (4) @(posedge clk);
        chk("torque", {16'h0, torque_limit}, 32'h0055);
        $display("test torque done");
        print_verdict();
    end
endmodule : positioning_chain_sequencer_tb_top
